/* logic/switch_reset_mode_control.sv */
`default_nettype none
module switch_reset_mode_control
  import reset_mode_pkg::*;
#(
  parameter int PROC_CYCLES = RESET_PROC_CYC    // Reset procedure length in clocks
)
(
  input  wire logic       mclk,                 // System clock 10 MHz
  input  wire logic       rst,                  // Async reset, active high
  input  wire logic       fundamental_reset_n,  // Fundamental reset, active low
  input  wire logic       reset_halt_request,   // Halt after reset procedure
  input  wire logic [3:0] switch_mode_strap,    // Mode straps
  input  wire logic       halt_bit_clear,       // Master cleared halt bit
  output logic            core_reset,           // Holds core logic in reset
  output logic            pcie_fund_reset,      // Fundamental reset in progress
  output logic            mgmt_bus_enable,      // Master and slave buses active
  output logic            reg_access_enable,    // Register access allowed
  output logic            halted,               // Halt bit state
  output mode_cfg_t       mode_cfg              // Captured mode decode
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  seq_state_t       state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             proc_done;
  logic [3:0]       mode_r, mode_nxt;
  logic             halt_req_r, halt_req_nxt;
  seq_out_t         out_r, out_nxt;
  logic             fund_r, fund_nxt;
  mode_cfg_t        cfg_r, cfg_nxt;
  mode_cfg_t        cfg_dec;

  // Decode the next code so the configuration shows at the capture edge
  switch_mode_decode i_switch_mode_decode
  (
    .code (mode_nxt),
    .cfg  (cfg_dec)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET:
      begin
        if (fundamental_reset_n)
        begin
          state_nxt = ST_PROC;
        end
      end
      ST_PROC:
      begin
        if (proc_done)
        begin
          state_nxt = halt_req_r ? ST_HALT : ST_RUN;
        end
      end
      ST_HALT:
      begin
        if (halt_bit_clear)
        begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN:
      begin
        state_nxt = ST_RUN;
      end
    endcase
    if (!fundamental_reset_n)
    begin
      state_nxt = ST_RESET;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Reset procedure counter
  // ----------------------------------------------------------------
  always_comb
  begin
    proc_done = (cnt_r == CNT_W'(PROC_CYCLES - 1));
    cnt_nxt   = '0;
    if ((state_r == ST_PROC) && !proc_done && fundamental_reset_n)
    begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Strap and halt capture
  // ----------------------------------------------------------------
  always_comb
  begin
    mode_nxt     = mode_r;
    halt_req_nxt = halt_req_r;
    if ((state_r == ST_RESET) && fundamental_reset_n)
    begin
      mode_nxt     = switch_mode_strap;
      halt_req_nxt = reset_halt_request;
    end
    if ((state_r == ST_HALT) && halt_bit_clear)
    begin
      halt_req_nxt = 1'b0;
    end
    if (!fundamental_reset_n)
    begin
      mode_nxt     = MODE_SINGLE;
      halt_req_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mode_r     <= MODE_SINGLE;
      halt_req_r <= 1'b0;
    end
    else
    begin
      mode_r     <= mode_nxt;
      halt_req_r <= halt_req_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_comb
  begin
    out_nxt  = '0;
    fund_nxt = 1'b0;
    unique case (state_nxt)
      ST_RESET:
      begin
        out_nxt.core_reset  = 1'b1;
        out_nxt.mgmt_enable = 1'b0;
        out_nxt.halted      = 1'b0;
        fund_nxt            = 1'b1;
      end
      ST_PROC:
      begin
        out_nxt.core_reset  = 1'b1;
        out_nxt.mgmt_enable = 1'b0;
        out_nxt.halted      = 1'b0;
        fund_nxt            = 1'b1;
      end
      ST_HALT:
      begin
        out_nxt.core_reset  = 1'b1;
        out_nxt.mgmt_enable = 1'b1;
        out_nxt.halted      = 1'b1;
        fund_nxt            = 1'b0;
      end
      ST_RUN:
      begin
        out_nxt.core_reset  = 1'b0;
        out_nxt.mgmt_enable = 1'b1;
        out_nxt.halted      = 1'b0;
        fund_nxt            = 1'b0;
      end
    endcase
    cfg_nxt = (state_nxt == ST_RESET) ? MODE_CFG_NONE : cfg_dec;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      out_r  <= '{core_reset: 1'b1, mgmt_enable: 1'b0, halted: 1'b0};
      fund_r <= 1'b1;
      cfg_r  <= MODE_CFG_NONE;
    end
    else
    begin
      out_r  <= out_nxt;
      fund_r <= fund_nxt;
      cfg_r  <= cfg_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign core_reset        = out_r.core_reset;
  assign pcie_fund_reset   = fund_r;
  assign mgmt_bus_enable   = out_r.mgmt_enable;
  assign reg_access_enable = out_r.mgmt_enable;
  assign halted            = out_r.halted;
  assign mode_cfg          = cfg_r;

endmodule
`default_nettype wire

/* logic/reset_mode_pkg.sv */
`default_nettype none
package reset_mode_pkg;

  // ----------------------------------------------------------------
  // Switch mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_SINGLE          = 4'h0;
  localparam logic [3:0] MODE_SINGLE_EE       = 4'h1;
  localparam logic [3:0] MODE_UP0             = 4'h8;
  localparam logic [3:0] MODE_UP2             = 4'h9;
  localparam logic [3:0] MODE_UP0_EE          = 4'hA;
  localparam logic [3:0] MODE_UP2_EE          = 4'hB;
  localparam logic [3:0] MODE_MULTI           = 4'hC;
  localparam logic [3:0] MODE_MULTI_EE        = 4'hD;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 100;
  localparam int RESET_PROC_NS   = 1000;
  localparam int RESET_PROC_CYC  = (RESET_PROC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 8;

  // ----------------------------------------------------------------
  // Decoded configuration
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic multi_partition;
    logic eeprom_init;
    logic fixed_upstream;
    logic upstream_port2;
    logic port0_disable;
    logic port2_disable;
  } mode_cfg_t;

  localparam mode_cfg_t MODE_CFG_NONE = '0;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET   = 4'h1,
    ST_PROC    = 4'h2,
    ST_HALT    = 4'h4,
    ST_RUN     = 4'h8
  } seq_state_t;

  typedef struct packed {
    logic core_reset;
    logic mgmt_enable;
    logic halted;
  } seq_out_t;

endpackage
`default_nettype wire

/* logic/switch_mode_decode.sv */
`default_nettype none
module switch_mode_decode
  import reset_mode_pkg::*;
(
  input  wire logic [3:0] code,  // Next mode code, before capture
  output mode_cfg_t       cfg    // Decoded configuration
);

  always_comb
  begin
    cfg = MODE_CFG_NONE;
    unique case (code)
      MODE_SINGLE:
      begin
        cfg.valid = 1'b1;
      end
      MODE_SINGLE_EE:
      begin
        cfg.valid       = 1'b1;
        cfg.eeprom_init = 1'b1;
      end
      MODE_UP0, MODE_UP0_EE:
      begin
        cfg.valid          = 1'b1;
        cfg.fixed_upstream = 1'b1;
        cfg.port2_disable  = 1'b1;
        cfg.eeprom_init    = (code == MODE_UP0_EE);
      end
      MODE_UP2, MODE_UP2_EE:
      begin
        cfg.valid          = 1'b1;
        cfg.fixed_upstream = 1'b1;
        cfg.upstream_port2 = 1'b1;
        cfg.port0_disable  = 1'b1;
        cfg.eeprom_init    = (code == MODE_UP2_EE);
      end
      MODE_MULTI, MODE_MULTI_EE:
      begin
        cfg.valid           = 1'b1;
        cfg.multi_partition = 1'b1;
        cfg.eeprom_init     = (code == MODE_MULTI_EE);
      end
      default:
      begin
        cfg = MODE_CFG_NONE;
      end
    endcase
  end

endmodule
`default_nettype wire

/* verif/reset_mode_chk.sv */
`default_nettype none
module reset_mode_chk
  import reset_mode_pkg::*;
(
  input wire logic       mclk,                // Clock
  input wire logic       rst,                 // Reset
  input wire logic       fundamental_reset_n, // Board reset
  input wire logic       reset_halt_request,  // Halt request
  input wire logic [3:0] switch_mode_strap,   // Straps
  input wire logic       halt_bit_clear,      // Halt clear
  input wire logic       core_reset,          // Core reset
  input wire logic       pcie_fund_reset,     // Procedure
  input wire logic       mgmt_bus_enable,     // Buses
  input wire logic       reg_access_enable,   // Access
  input wire logic       halted,              // Halted
  input wire mode_cfg_t  mode_cfg             // Mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  fund_reset_a:
    assert property (!fundamental_reset_n |=> core_reset && pcie_fund_reset && !mgmt_bus_enable
      && mode_cfg == '0) else $error("fundamental reset not applied");
  proc_len_a:
    assert property (disable iff (rst || !fundamental_reset_n) $rose(fundamental_reset_n)
      |-> pcie_fund_reset[*8] ##1 pcie_fund_reset[*3] ##1 !pcie_fund_reset)
      else $error("procedure length wrong");
  halt_hold_a:
    assert property (disable iff (rst || !fundamental_reset_n) halted && !halt_bit_clear
      |=> halted) else $error("halt left without clear");
  halt_exit_a:
    assert property (disable iff (rst || !fundamental_reset_n) halted && halt_bit_clear
      |=> (!core_reset && !halted)) else $error("halt not left after clear");
  halt_bus_a:
    assert property (halted |-> mgmt_bus_enable && core_reset && !pcie_fund_reset)
      else $error("halt outputs wrong");
  access_a:
    assert property (reg_access_enable == mgmt_bus_enable
      && reg_access_enable == (halted || !core_reset)) else $error("access enable wrong");
  proc_quiet_a:
    assert property (pcie_fund_reset |-> core_reset && !mgmt_bus_enable && !halted)
      else $error("procedure outputs wrong");
  cfg_hold_a:
    assert property (mode_cfg.valid && fundamental_reset_n |=> $stable(mode_cfg))
      else $error("mode changed after capture");
endmodule
bind switch_reset_mode_control reset_mode_chk i_reset_mode_chk (.mclk(mclk), .rst(rst),
  .fundamental_reset_n(fundamental_reset_n), .reset_halt_request(reset_halt_request),
  .switch_mode_strap(switch_mode_strap), .halt_bit_clear(halt_bit_clear),
  .core_reset(core_reset), .pcie_fund_reset(pcie_fund_reset), .halted(halted),
  .mgmt_bus_enable(mgmt_bus_enable), .reg_access_enable(reg_access_enable), .mode_cfg(mode_cfg));
`default_nettype wire

/* verif/board_mgmt_model.sv */
`default_nettype none
module board_mgmt_model
(
  input  wire logic       mclk,                // Clock
  output logic            fundamental_reset_n, // Board reset
  output logic            reset_halt_request,  // Halt request
  output logic [3:0]      switch_mode_strap,   // Straps
  output logic            halt_bit_clear       // Halt clear
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    fundamental_reset_n = 1'b0;
    reset_halt_request = 1'b0;
    switch_mode_strap = 4'h0;
    halt_bit_clear = 1'b0;
  end
  task automatic board_reset(input logic halt, input logic [3:0] code);
    @(negedge mclk);
    fundamental_reset_n = 1'b0;
    reset_halt_request = halt;
    switch_mode_strap = code;
    repeat (3) @(negedge mclk);
    fundamental_reset_n = 1'b1;
  endtask
  task automatic set_strap(input logic [3:0] code);
    switch_mode_strap = code;
  endtask
  task automatic clear_halt();
    @(negedge mclk);
    halt_bit_clear = 1'b1;
    @(negedge mclk);
    halt_bit_clear = 1'b0;
  endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
`default_nettype none
module testbench;
  import reset_mode_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic      mclk = 1'b0;
  logic      rst = 1'b1;
  wire logic fund_n, halt_req, clr, core_reset, fund_rst, bus_en, acc_en, halted;
  wire logic [3:0] strap;
  mode_cfg_t mode_cfg;
  int        num_errors = 0;
  int        comparisons = 0;
  always #50 mclk = ~mclk;
  board_mgmt_model i_board_mgmt_model (.mclk(mclk), .fundamental_reset_n(fund_n),
    .reset_halt_request(halt_req), .switch_mode_strap(strap), .halt_bit_clear(clr));
  switch_reset_mode_control i_switch_reset_mode_control (.mclk(mclk), .rst(rst),
    .fundamental_reset_n(fund_n), .reset_halt_request(halt_req), .switch_mode_strap(strap),
    .halt_bit_clear(clr), .core_reset(core_reset), .pcie_fund_reset(fund_rst),
    .mgmt_bus_enable(bus_en), .reg_access_enable(acc_en), .halted(halted), .mode_cfg(mode_cfg));
  task automatic check(input string what, input logic [6:0] exp, input logic [6:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic wait_for(input logic halt);
    int n = 0;
    while (n < 40 && (halt ? halted !== 1'b1 : core_reset !== 1'b0))
    begin
      @(negedge mclk);
      n++;
    end
    if (halt ? halted !== 1'b1 : core_reset !== 1'b0)
    begin
      $display("CHECK FAILED wait_for expected done seen timeout");
      num_errors++;
    end
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic test_modes();
    logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
    logic [6:0] cfgs [8] = '{7'h40, 7'h50, 7'h49, 7'h4E, 7'h59, 7'h5E, 7'h60, 7'h70};
    for (int i = 0; i < 8; i++)
    begin
      i_board_mgmt_model.board_reset(1'b0, codes[i]);
      wait_for(1'b0);
      check("mode_cfg", cfgs[i], mode_cfg);
      check("bus_enable", 7'h1, bus_en);
      check("pcie_fund_reset", 7'h0, fund_rst);
    end
    $display("test_modes done");
  endtask
  task automatic test_halt();
    i_board_mgmt_model.board_reset(1'b1, 4'hC);
    i_board_mgmt_model.clear_halt();
    wait_for(1'b1);
    check("halted", 7'h1, halted);
    check("reg_access", 7'h1, acc_en);
    i_board_mgmt_model.set_strap(4'h1);
    repeat (20) @(negedge mclk);
    check("core_reset", 7'h1, core_reset);
    i_board_mgmt_model.clear_halt();
    repeat (2) @(negedge mclk);
    check("core_reset", 7'h0, core_reset);
    check("mode_cfg", 7'h60, mode_cfg);
    $display("test_halt done");
  endtask
  task automatic test_resets();
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    check("core_reset", 7'h1, core_reset);
    check("mode_cfg", 7'h0, mode_cfg);
    check("pcie_fund_reset", 7'h1, fund_rst);
    check("bus_enable", 7'h0, bus_en);
    wait_for(1'b1);
    check("mode_cfg", 7'h50, mode_cfg);
    i_board_mgmt_model.board_reset(1'b0, 4'hD);
    wait_for(1'b0);
    check("mode_cfg", 7'h70, mode_cfg);
    $display("test_resets done");
  endtask
  initial
  begin
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    test_modes();
    test_halt();
    test_resets();
    complete_run();
  end
  initial
  begin
    #100000;
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
